// *** hw/dvcs_pkg.sv ***
/*
  Constants and types shared by the dynamic voltage code stepper.
  Assumes a 200 MHz system clock; both tick dividers are derived from it here.
*/
package dvcs_pkg;

  // ==========================================================================
  // clocking
  // ==========================================================================
  localparam int CLK_FREQ_KHZ    = 200000;
  localparam int SAMPLE_FREQ_KHZ = 5550;
  localparam int STEP_FREQ_KHZ   = 1850;
  // a tick period is a longest time: round down
  localparam int SAMPLE_DIV      = CLK_FREQ_KHZ / SAMPLE_FREQ_KHZ;
  localparam int STEP_DIV        = CLK_FREQ_KHZ / STEP_FREQ_KHZ;

  // ==========================================================================
  // code qualification
  // ==========================================================================
  localparam int         ACCEPT_SAMPLES   = 3;
  localparam int         SHUTDOWN_SAMPLES = 4;
  localparam int         STABLE_W         = 3;
  localparam logic [2:0] STABLE_MAX       = 3'h4;
  localparam logic [2:0] STABLE_ONE       = 3'h1;
  localparam logic [2:0] STABLE_ACCEPT    = 3'h3;
  localparam logic [2:0] STABLE_SHUTDOWN  = 3'h4;

  // ==========================================================================
  // code table
  // ==========================================================================
  localparam int          CODE_W        = 8;
  localparam int          LEVEL_W       = 21;
  // level in microvolts: top minus code times step
  localparam logic [20:0] LEVEL_TOP_UV  = 21'h189ad4;
  localparam logic [20:0] STEP_UV       = 21'h00186a;
  localparam logic [7:0]  CODE_LOWEST   = 8'hb2;
  localparam logic [7:0]  CODE_OFF_A    = 8'hfe;
  localparam logic [7:0]  CODE_OFF_B    = 8'hff;
  localparam logic [7:0]  DAC_RESET     = 8'hb2;

  // ==========================================================================
  // types
  // ==========================================================================
  typedef enum logic [1:0] {
    DVCS_ST_IDLE,
    DVCS_ST_ACQUIRE,
    DVCS_ST_RUN,
    DVCS_ST_SHUTDOWN
  } dvcs_state_t;

  typedef struct packed {
    logic regulate;
    logic shutdown_latched;
    logic slewing;
    logic code_valid;
  } dvcs_status_t;

endpackage

// *** hw/dvcs_tick.sv ***
/*
  Free-running divider giving a one-cycle tick every DIV system clocks.
  Assumes DIV of at least two.
*/
`timescale 1ns/1ps
module dvcs_tick
  import dvcs_pkg::*;
#(
  parameter int DIV = 36
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  output logic      tick
);

  localparam int CNT_W = $clog2(DIV);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DIV - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_INC  = CNT_W'(1);

  logic [CNT_W-1:0] count;
  wire              at_last = (count == CNT_LAST);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count <= CNT_ZERO;
      tick  <= 1'b0;
    end else begin
      count <= at_last ? CNT_ZERO : count + CNT_INC;
      tick  <= at_last;
    end
  end

endmodule

// *** hw/dvcs_top.sv ***
/*
  Dynamic voltage code stepper: qualifies the processor's voltage select code,
  slews the internal DAC code one step at a time and latches off on shutdown
  codes.
  Assumes voltage_select_code and enable come from pins, asynchronous to
  clk_sys; dac_code and reference_level feed the analog reference.
*/
// What this block does
// - each code step lowers the level by 6.25mV; b2 is the lowest at 0.5V; fe and ff shut down.
// - the select inputs are sampled and compared with the previous sample on every 5.55MHz sample tick.
// - a differing code becomes the target only after 3 identical consecutive samples.
// - the DAC code moves one step toward the target on every 1.85MHz step tick.
// - stepping stops and the DAC code holds once it equals the target.
// - a shutdown code is recognised after 4 identical samples and turns regulation off.
// - shutdown stays latched until enable is dropped; raising it again restarts acquisition.
`timescale 1ns/1ps
module dvcs_top
  import dvcs_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                enable,
  input  wire logic [CODE_W-1:0]   voltage_select_code,
  output logic      [CODE_W-1:0]   dac_code,
  output logic      [LEVEL_W-1:0]  reference_level,
  output dvcs_status_t             status
);

  // ==========================================================================
  // input synchronisers
  // ==========================================================================
  logic [CODE_W-1:0] vsel_meta;
  logic [CODE_W-1:0] vsel_sync;
  logic              en_meta;
  logic              en_sync;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      vsel_meta <= '0;
      vsel_sync <= '0;
      en_meta   <= 1'b0;
      en_sync   <= 1'b0;
    end else begin
      vsel_meta <= voltage_select_code;
      vsel_sync <= vsel_meta;
      en_meta   <= enable;
      en_sync   <= en_meta;
    end
  end

  // ==========================================================================
  // sample and step ticks
  // ==========================================================================
  logic sample_tick;
  logic step_tick;

  dvcs_tick #(
    .DIV (SAMPLE_DIV)
  ) u_sample_tick (
    .clk_sys (clk_sys),
    .rst     (rst),
    .tick    (sample_tick)
  );

  dvcs_tick #(
    .DIV (STEP_DIV)
  ) u_step_tick (
    .clk_sys (clk_sys),
    .rst     (rst),
    .tick    (step_tick)
  );

  // ==========================================================================
  // stability counting
  // ==========================================================================
  logic [CODE_W-1:0]   last_sample;
  logic [STABLE_W-1:0] stable_cnt;

  wire                 same_sample  = (vsel_sync == last_sample);
  wire                 stable_sat   = (stable_cnt == STABLE_MAX);
  wire [STABLE_W-1:0]  stable_inc   = stable_sat ? stable_cnt : stable_cnt + STABLE_ONE;
  wire [STABLE_W-1:0]  next_stable  = same_sample ? stable_inc : STABLE_ONE;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      last_sample <= '0;
      stable_cnt  <= '0;
    end else if (sample_tick) begin
      last_sample <= vsel_sync;
      stable_cnt  <= next_stable;
    end
  end

  // ==========================================================================
  // code decode
  // ==========================================================================
  // codes beyond the lowest entry that are not shutdown clamp to the lowest level
  wire              is_off_code   = (vsel_sync == CODE_OFF_A) || (vsel_sync == CODE_OFF_B);
  wire              below_lowest  = (vsel_sync > CODE_LOWEST) && !is_off_code;
  wire [CODE_W-1:0] sample_target = below_lowest ? CODE_LOWEST : vsel_sync;

  wire              code_stable   = sample_tick && (next_stable >= STABLE_ACCEPT);
  wire              off_stable    = sample_tick && is_off_code &&
                                    (next_stable >= STABLE_SHUTDOWN);
  logic [CODE_W-1:0] target;

  // a code met mid-slew at the present DAC code still becomes the target
  wire              new_target    = code_stable && !is_off_code &&
                                    ((sample_target != dac_code) ||
                                     (sample_target != target));

  // ==========================================================================
  // control state
  // ==========================================================================
  dvcs_state_t state;
  dvcs_state_t next_state;

  always_comb begin
    next_state = state;
    case (state)
      DVCS_ST_IDLE: begin
        if (en_sync) begin
          next_state = DVCS_ST_ACQUIRE;
        end
      end
      DVCS_ST_ACQUIRE: begin
        if (!en_sync) begin
          next_state = DVCS_ST_IDLE;
        end else if (off_stable) begin
          next_state = DVCS_ST_SHUTDOWN;
        end else if (code_stable && !is_off_code) begin
          next_state = DVCS_ST_RUN;
        end
      end
      DVCS_ST_RUN: begin
        if (!en_sync) begin
          next_state = DVCS_ST_IDLE;
        end else if (off_stable) begin
          next_state = DVCS_ST_SHUTDOWN;
        end
      end
      DVCS_ST_SHUTDOWN: begin
        // only an enable low clears the latch
        if (!en_sync) begin
          next_state = DVCS_ST_IDLE;
        end
      end
      default: begin
        next_state = DVCS_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= DVCS_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // target and DAC stepping
  // ==========================================================================
  logic [CODE_W-1:0] next_target;
  logic [CODE_W-1:0] next_dac;

  wire               in_run     = (state == DVCS_ST_RUN) && (next_state == DVCS_ST_RUN);
  wire               acquiring  = (state == DVCS_ST_ACQUIRE) && (next_state == DVCS_ST_RUN);
  // a target taken this cycle steers this cycle's step, so no overshoot
  wire [CODE_W-1:0]  run_target = new_target ? sample_target : target;
  wire               dac_below  = (dac_code < run_target);
  wire               dac_above  = (dac_code > run_target);
  wire [CODE_W-1:0]  dac_up     = dac_code + CODE_W'(1);
  wire [CODE_W-1:0]  dac_down   = dac_code - CODE_W'(1);

  always_comb begin
    next_target = target;
    next_dac    = dac_code;
    if (acquiring) begin
      // first qualified code after enable seeds both
      next_target = sample_target;
      next_dac    = sample_target;
    end else if (in_run) begin
      if (new_target) begin
        next_target = sample_target;
      end
      if (step_tick && dac_below) begin
        next_dac = dac_up;
      end else if (step_tick && dac_above) begin
        next_dac = dac_down;
      end else begin
        next_dac = dac_code;
      end
    end else if (state == DVCS_ST_IDLE) begin
      next_target = DAC_RESET;
      next_dac    = DAC_RESET;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      target   <= DAC_RESET;
      dac_code <= DAC_RESET;
    end else begin
      target   <= next_target;
      dac_code <= next_dac;
    end
  end

  // ==========================================================================
  // reference level and status
  // ==========================================================================
  wire [LEVEL_W-1:0] code_wide  = {{(LEVEL_W-CODE_W){1'b0}}, next_dac};
  wire [LEVEL_W-1:0] drop_uv    = LEVEL_W'(code_wide * STEP_UV);
  wire [LEVEL_W-1:0] next_level = LEVEL_TOP_UV - drop_uv;

  dvcs_status_t next_status;

  always_comb begin
    next_status                  = '0;
    next_status.regulate         = (next_state == DVCS_ST_RUN);
    next_status.shutdown_latched = (next_state == DVCS_ST_SHUTDOWN);
    next_status.slewing          = (next_state == DVCS_ST_RUN) && (next_dac != next_target);
    next_status.code_valid       = (next_state == DVCS_ST_RUN);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reference_level <= LEVEL_TOP_UV - LEVEL_W'({{(LEVEL_W-CODE_W){1'b0}}, DAC_RESET} * STEP_UV);
      status          <= '0;
    end else begin
      reference_level <= next_level;
      status          <= next_status;
    end
  end

endmodule

// *** verif/dvcs_props.sv ***
/*
  Port assertions for dvcs_top, bound into every instance.
  Assumes one clock, clk_sys, and rst asynchronous active high.
*/
`timescale 1ns/1ps
module dvcs_props
  import dvcs_pkg::*;
(
  input wire logic                clk_sys,
  input wire logic                rst,
  input wire logic                enable,
  input wire logic [CODE_W-1:0]   voltage_select_code,
  input wire logic [CODE_W-1:0]   dac_code,
  input wire logic [LEVEL_W-1:0]  reference_level,
  input wire dvcs_status_t        status
);
  // ==========================================
  // helpers: cycles since the last code move
  logic [CODE_W-1:0] prev_dac;
  logic [7:0]        gap;
  logic              stepped;
  wire               chg = dac_code != prev_dac;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prev_dac <= DAC_RESET;
      gap      <= 8'h00;
      stepped  <= 1'b0;
    end else begin
      prev_dac <= dac_code;
      gap      <= chg ? 8'h00 : (gap == 8'hff ? gap : gap + 8'h01);
      stepped  <= status.regulate & (stepped | chg);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ==========================================
  // assertions
  a_level_map: assert property (reference_level == LEVEL_TOP_UV - STEP_UV * 21'(dac_code))
    else $error("level does not match code");
  a_step_one: assert property (status.regulate && $past(status.regulate)
    && $changed(dac_code)
    |-> dac_code == $past(dac_code) + 8'h01 || dac_code == $past(dac_code) - 8'h01)
    else $error("code moved by more than one step");
  a_step_gap: assert property (chg && status.regulate && stepped |-> gap >= 8'h64)
    else $error("steps too close together");
  a_step_due: assert property (status.slewing && status.regulate
    |-> ##[1:120] ($changed(dac_code) || !status.slewing))
    else $error("slew step missing");
  a_accept_three: assert property ($rose(status.slewing) && $past(status.regulate)
    |-> $past(voltage_select_code, 6) == $past(voltage_select_code, 66))
    else $error("target taken from an unstable code");
  a_off_recog: assert property ($rose(status.shutdown_latched)
    |-> $past(voltage_select_code, 110) >= CODE_OFF_A)
    else $error("shutdown without a held off code");
  a_shut_quiet: assert property (status.shutdown_latched
    |-> !status.regulate && !status.slewing)
    else $error("regulating while shut down");
  a_shut_hold: assert property (status.shutdown_latched && enable && $past(enable)
    && $past(enable, 2) && $past(enable, 3) |=> status.shutdown_latched && $stable(dac_code))
    else $error("shutdown latch released");
  a_idle_clear: assert property (!enable && !$past(enable) && !$past(enable, 2)
    && !$past(enable, 3) |=> !status.regulate && !status.shutdown_latched)
    else $error("not idle with enable low");

  c_run: cover property ($rose(status.regulate));
  c_slew: cover property ($rose(status.slewing));
  c_off: cover property ($rose(status.shutdown_latched));
endmodule

bind dvcs_top dvcs_props u_props (
  .clk_sys(clk_sys), .rst(rst), .enable(enable), .voltage_select_code(voltage_select_code),
  .dac_code(dac_code), .reference_level(reference_level), .status(status)
);

// *** verif/dvcs_cpu.sv ***
/*
  Processor model driving the voltage select pins.
  Assumes the bench calls put; pins move 1 ns after a clock edge.
*/
`timescale 1ns/1ps
module dvcs_cpu
  import dvcs_pkg::*;
(
  input  wire logic              clk_sys,
  output logic      [CODE_W-1:0] voltage_select_code
);
  initial voltage_select_code = DAC_RESET;
  // drive a code, then hold it n clocks
  task automatic put(input logic [CODE_W-1:0] c, input int n);
    @(posedge clk_sys);
    #1 voltage_select_code = c;
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
endmodule

// *** verif/dvcs_top_tb.sv ***
/*
  Self-checking bench for dvcs_top.
  Assumes dvcs_cpu as the processor, 200 MHz clock, 12-cycle reset.
*/
`timescale 1ns/1ps
module dvcs_top_tb;
  import dvcs_pkg::*;
  logic               clk_sys = 1'b0;
  logic               rst = 1'b1;
  logic               enable = 1'b0;
  logic [CODE_W-1:0]  vsc;
  logic [CODE_W-1:0]  dac_code;
  logic [LEVEL_W-1:0] reference_level;
  dvcs_status_t       status;
  int                 n_errors = 0;
  int                 cmp_count = 0;

  always #2.5 clk_sys = ~clk_sys;

  dvcs_cpu cpu (.clk_sys(clk_sys), .voltage_select_code(vsc));
  dvcs_top DUT (
    .clk_sys(clk_sys), .rst(rst), .enable(enable), .voltage_select_code(vsc),
    .dac_code(dac_code), .reference_level(reference_level), .status(status)
  );

  // ==========================================
  // common tasks
  task automatic close_out;
    if (n_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic [20:0] lvl(input logic [7:0] c);
    return LEVEL_TOP_UV - STEP_UV * 21'(c);
  endfunction

  // wait until the code rests at d
  task automatic settle(input logic [7:0] d, input int n);
    int i;
    for (i = 0; i < n && !(dac_code === d && status.slewing === 1'b0); i++) begin
      @(posedge clk_sys);
      #1;
    end
    if (i == n) begin
      n_errors++;
      $display("CHECK FAILED %0t no settle at %h", $time, d);
      close_out();
    end
  endtask

  // ==========================================
  // scenarios
  task automatic sc_start;
    @(posedge clk_sys);
    #1 enable = 1'b1;
    cpu.put(8'h90, 110);
    settle(8'h90, 200);
    chk(reference_level, lvl(8'h90));
    chk(status, 21'h9);
  endtask

  task automatic sc_glitch;
    // held for exactly two samples: one short of acceptance
    cpu.put(8'h80, 71);
    cpu.put(8'h90, 0);
    repeat (300) begin
      @(posedge clk_sys);
      #1;
      chk(dac_code, 8'h90);
    end
  endtask

  task automatic sc_slew;
    cpu.put(8'h98, 250);
    chk(status.slewing, 1'b1);
    cpu.put(8'h92, 0);
    settle(8'h92, 1500);
    repeat (300) @(posedge clk_sys);
    #1;
    chk(dac_code, 8'h92);
    cpu.put(8'h8e, 0);
    settle(8'h8e, 800);
  endtask

  task automatic sc_clamp;
    cpu.put(8'hc0, 0);
    settle(8'hb2, 4100);
    chk(reference_level, 21'h07a120);
  endtask

  task automatic sc_off;
    // off code seen on exactly three samples must be ignored
    cpu.put(8'hff, 107);
    cpu.put(8'hb0, 400);
    chk(status.shutdown_latched, 1'b0);
    chk(dac_code, 8'hb0);
    cpu.put(8'hfe, 200);
    chk(status, 21'h4);
    cpu.put(8'h90, 300);
    chk(status, 21'h4);
    chk(dac_code, 8'hb0);
  endtask

  task automatic sc_restart;
    @(posedge clk_sys);
    #1 enable = 1'b0;
    repeat (8) @(posedge clk_sys);
    #1;
    chk(status, 21'h0);
    chk(dac_code, 8'hb2);
    enable = 1'b1;
    settle(8'h90, 300);
    chk(status, 21'h9);
  endtask

  initial begin
    repeat (12) @(posedge clk_sys);
    #1 rst = 1'b0;
    chk(dac_code, 8'hb2);
    chk(reference_level, 21'h07a120);
    chk(status, 21'h0);
    sc_start();
    sc_glitch();
    sc_slew();
    sc_clamp();
    sc_off();
    sc_restart();
    close_out();
  end

  initial begin
    repeat (60000) @(posedge clk_sys);
    n_errors++;
    $display("CHECK FAILED %0t run too long", $time);
    close_out();
  end
endmodule
